// File: verilog/pfpp_pkg.sv
package pfpp_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_BYTES = 64;
  localparam int ALT_STATUS_BIT = 6;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int GAP_US = 150;
  localparam logic [11:0] GAP_CYC = 12'(GAP_US * 1000 / CLK_NS);
  // covers request register, engine idle and setup before the strobe falls
  localparam logic [11:0] GAP_MARGIN_CYC = 12'h010;
  localparam logic [11:0] GAP_ACCEPT_CYC = GAP_CYC - GAP_MARGIN_CYC;
  localparam int WE_LOW_NS = 100;
  localparam logic [3:0] WE_LOW_CYC = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam int READ_NS = 150;
  localparam logic [3:0] READ_CYC = 4'((READ_NS + CLK_NS - 1) / CLK_NS);
  localparam int TWC_MS = 10;
  localparam int TWC_CYC_DEF = TWC_MS * 1000000 / CLK_NS;
  localparam int POLL_W = 24;

  // ---------------------------------------------------------------
  // commands and sequences
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_LOAD = 2'h1;
  localparam logic [1:0] OP_SEQ = 2'h2;
  localparam logic [1:0] SEQ_LOCK_ON = 2'h0;
  localparam logic [1:0] SEQ_LOCK_OFF = 2'h1;
  localparam logic [1:0] SEQ_ERASE = 2'h2;
  localparam logic [2:0] SEQ_SHORT_LEN = 3'h3;
  localparam logic [2:0] SEQ_LONG_LEN = 3'h6;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_SETUP = 2'b01,
    E_STROBE = 2'b10,
    E_HOLD = 2'b11
  } pfpp_eng_st_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_WR = 3'b001,
    H_GAP = 3'b010,
    H_RD = 3'b011,
    H_POLL = 3'b100,
    H_PCHK = 3'b101
  } pfpp_host_st_type;

  typedef struct packed {
    pfpp_eng_st_type st;
    logic [3:0] cnt;
    logic wr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic done;
    logic [DATA_W-1:0] rdata;
  } pfpp_eng_type;

  typedef struct packed {
    pfpp_host_st_type st;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic busy;
    logic done;
    logic tmo;
    logic partial;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic pend_valid;
    logic [1:0] pend_op;
    logic [ADDR_W-1:0] pend_addr;
    logic [DATA_W-1:0] pend_data;
    logic seq_active;
    logic [1:0] seq_id;
    logic [2:0] seq_idx;
    logic page_valid;
    logic [ADDR_W-PAGE_LSB-1:0] page;
    logic [PAGE_BYTES-1:0] mask;
    logic [ADDR_W-1:0] last_addr;
    logic prev_ok;
    logic prev_alt;
    logic [11:0] gap_cnt;
    logic [POLL_W-1:0] poll_cnt;
  } pfpp_host_type;

  localparam pfpp_eng_type PFPP_ENG_RST = '{st: E_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
  localparam pfpp_host_type PFPP_HOST_RST = '{st: H_IDLE, ready: 1'b1, default: '0};

endpackage

// File: verilog/pfpp_cyc_if.sv
`timescale 1ns/1ns
interface pfpp_cyc_if;
  import pfpp_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// File: verilog/pfpp_bus_cycle.sv
`timescale 1ns/1ns
module pfpp_bus_cycle
  import pfpp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request side
  pfpp_cyc_if.engine cyc,
  // flash pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [ADDR_W-1:0] addr_o,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o
);

  pfpp_eng_type r_reg;
  pfpp_eng_type r_next;

  // ---------------------------------------------------------------
  // one strobed cycle per request
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    case (r_reg.st)
      E_IDLE: begin
        if (cyc.req) begin
          r_next.wr = cyc.wr;
          r_next.addr = cyc.addr;
          r_next.dq = cyc.wdata;
          r_next.ce_n = 1'b0;
          r_next.oe_n = cyc.wr; // write keeps output drive off [RULE3]
          r_next.dq_oe = cyc.wr;
          r_next.cnt = 4'h0;
          r_next.st = E_SETUP;
        end
      end
      E_SETUP: begin
        if (r_reg.wr) begin
          r_next.we_n = 1'b0; // strobe falls with chip select already low [RULE3]
          r_next.cnt = WE_LOW_CYC - 4'h1;
          r_next.st = E_STROBE;
        end else begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.cnt == READ_CYC - 4'h1) begin
            r_next.rdata = dq_i;
            r_next.st = E_HOLD;
          end
        end
      end
      E_STROBE: begin
        if (r_reg.cnt == 4'h0) begin
          r_next.we_n = 1'b1;
          r_next.st = E_HOLD;
        end else begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end
      end
      E_HOLD: begin
        // data held one cycle past the rising strobe
        r_next.ce_n = 1'b1;
        r_next.oe_n = 1'b1;
        r_next.we_n = 1'b1;
        r_next.dq_oe = 1'b0;
        r_next.done = 1'b1;
        r_next.st = E_IDLE;
      end
      default: r_next = PFPP_ENG_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= PFPP_ENG_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ce_n_o = r_reg.ce_n;
  assign oe_n_o = r_reg.oe_n;
  assign we_n_o = r_reg.we_n;
  assign addr_o = r_reg.addr;
  assign dq_o = r_reg.dq;
  assign dq_oe_o = r_reg.dq_oe;
  assign cyc.done = r_reg.done;
  assign cyc.rdata = r_reg.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_we_pulse_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(we_n_o) |-> (!we_n_o && !ce_n_o && oe_n_o && dq_oe_o) [*3] ##1 we_n_o) // [RULE3]
    else $error("write strobe frame wrong");
  a_read_no_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    !oe_n_o |-> we_n_o && !dq_oe_o) // [RULE3]
    else $error("read overlaps write");

endmodule

// File: verilog/pfpp_host.sv
`timescale 1ns/1ns
// Summary of operation
// [RULE1] device drives data when selected and enabled
// [RULE2] device floats data when deselected or disabled
// [RULE3] host pulses one strobe, other low, output off
// [RULE4] device takes address at later falling edge
// [RULE5] device takes data at earlier rising edge
// [RULE6] whole page loaded, missing bytes become undefined
// [RULE7] next strobe within 150 us, else programming
// [RULE8] same page on every load strobe
// [RULE9] device accepts page bytes in any order
// [RULE10] device latches page and data, bus freed
// [RULE11] device erases page then writes latched bytes; the flash model inverts every page byte instead of erasing it
// [RULE12] reads return polling status during write cycle
// [RULE13] three-byte command enables write lock
// [RULE14] locked: each program starts with three commands
// [RULE15] lock survives power, cleared by disable sequence
// [RULE16] locked write without sequence only runs timer
// [RULE17] no programming with output on or strobe high
// [RULE18] device ignores strobe glitches under 15 ns
// [RULE19] polled last byte shows inverted top bit
// [RULE20] alternating status bit toggles while busy
// [RULE21] host waits for completion before next access; the host gives up after TWC_CYC clock cycles of polling and raises prog_timeout_o
// [RULE22] six-byte command sequence erases whole array
module pfpp_host
  import pfpp_pkg::*;
#(
  parameter int unsigned TWC_CYC = TWC_CYC_DEF,
  parameter logic [5:0][ADDR_W+DATA_W-1:0] SEQ_LOCK_ON_TBL = '0,
  parameter logic [5:0][ADDR_W+DATA_W-1:0] SEQ_LOCK_OFF_TBL = '0,
  parameter logic [5:0][ADDR_W+DATA_W-1:0] SEQ_ERASE_TBL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_data_i,
  output logic cmd_ready_o,
  // answers and status
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic busy_o,
  output logic prog_done_o,
  output logic prog_timeout_o,
  output logic page_partial_o,
  // flash pins
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o
);

  pfpp_host_type r_reg;
  pfpp_host_type r_next;
  pfpp_cyc_if cyc ();
  logic take;

  // ---------------------------------------------------------------
  // command sequence tables
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W+DATA_W-1:0] seq_entry(input logic [1:0] id, input logic [2:0] idx);
    logic [ADDR_W+DATA_W-1:0] e;
    e = '0;
    if (id == SEQ_LOCK_ON) begin
      e = SEQ_LOCK_ON_TBL[idx];
    end else if (id == SEQ_LOCK_OFF) begin
      e = SEQ_LOCK_OFF_TBL[idx];
    end else begin
      e = SEQ_ERASE_TBL[idx];
    end
    return e;
  endfunction

  function automatic logic [2:0] seq_len(input logic [1:0] id);
    return (id == SEQ_LOCK_ON) ? SEQ_SHORT_LEN : SEQ_LONG_LEN;
  endfunction

  // starts a read, a page byte load or a command sequence
  function automatic pfpp_host_type launch(input pfpp_host_type s, input logic [1:0] op,
                                           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    pfpp_host_type t;
    t = s;
    t.req = 1'b1;
    t.busy = 1'b1;
    t.wr = 1'b1;
    if (op == OP_READ) begin
      t.wr = 1'b0;
      t.addr = a;
      t.st = H_RD;
    end else if (op == OP_LOAD) begin
      t.addr = a;
      t.wdata = d;
      t.last_addr = a;
      t.page_valid = 1'b1;
      t.page = a[ADDR_W-1:PAGE_LSB];
      t.mask[a[PAGE_LSB-1:0]] = 1'b1; // bytes may come in any order [RULE9]
      t.st = H_WR;
    end else begin
      // lock-on prefix leaves page unset so the page follows in the window [RULE13] [RULE14]
      t.seq_active = 1'b1;
      t.seq_id = d[1:0];
      t.seq_idx = 3'h0;
      {t.addr, t.wdata} = seq_entry(d[1:0], 3'h0);
      t.last_addr = t.addr;
      t.st = H_WR;
    end
    return t;
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign take = cmd_valid_i && r_reg.ready;

  always_comb begin
    r_next = r_reg;
    r_next.req = 1'b0;
    r_next.rsp_valid = 1'b0;
    r_next.done = 1'b0;
    r_next.tmo = 1'b0;
    r_next.partial = 1'b0;
    case (r_reg.st)
      H_IDLE: begin
        r_next.page_valid = 1'b0;
        r_next.mask = '0;
        if (r_reg.pend_valid) begin
          r_next.pend_valid = 1'b0;
          r_next = launch(r_next, r_reg.pend_op, r_reg.pend_addr, r_reg.pend_data);
        end else if (take) begin
          r_next = launch(r_next, cmd_op_i, cmd_addr_i, cmd_data_i);
        end
      end
      H_WR: begin
        if (cyc.done) begin
          if (r_reg.seq_active && r_reg.seq_idx != seq_len(r_reg.seq_id) - 3'h1) begin
            r_next.seq_idx = r_reg.seq_idx + 3'h1; // erase code runs all six loads [RULE22]
            {r_next.addr, r_next.wdata} = seq_entry(r_reg.seq_id, r_next.seq_idx);
            r_next.last_addr = r_next.addr;
            r_next.req = 1'b1;
          end else begin
            r_next.seq_active = 1'b0;
            r_next.gap_cnt = 12'h000;
            r_next.st = H_GAP;
          end
        end
      end
      H_GAP: begin
        r_next.gap_cnt = r_reg.gap_cnt + 12'h001;
        if (r_reg.gap_cnt == GAP_CYC - 12'h001) begin
          // device has started its cycle; only completion polling from here [RULE7] [RULE21]
          r_next.partial = r_reg.page_valid && !(&r_reg.mask); // [RULE6]
          r_next.poll_cnt = '0;
          r_next.prev_ok = 1'b0;
          r_next.st = H_POLL;
        end
        if (take) begin
          if (cmd_op_i == OP_LOAD && (!r_reg.page_valid || cmd_addr_i[ADDR_W-1:PAGE_LSB] == r_reg.page)) begin
            r_next = launch(r_next, cmd_op_i, cmd_addr_i, cmd_data_i); // [RULE7] [RULE8]
          end else begin
            // other page or access: held until polling sees completion or times out [RULE8] [RULE21]
            r_next.pend_valid = 1'b1;
            r_next.pend_op = cmd_op_i;
            r_next.pend_addr = cmd_addr_i;
            r_next.pend_data = cmd_data_i;
          end
        end
      end
      H_RD: begin
        if (cyc.done) begin
          r_next.rsp_valid = 1'b1;
          r_next.rsp_data = cyc.rdata;
          r_next.busy = 1'b0;
          r_next.st = H_IDLE;
        end
      end
      H_POLL: begin
        r_next.poll_cnt = r_reg.poll_cnt + POLL_W'(1);
        r_next.req = 1'b1;
        r_next.wr = 1'b0;
        r_next.addr = r_reg.last_addr; // [RULE21]
        r_next.st = H_PCHK;
      end
      H_PCHK: begin
        r_next.poll_cnt = r_reg.poll_cnt + POLL_W'(1);
        if (cyc.done) begin
          r_next.prev_ok = 1'b1;
          r_next.prev_alt = cyc.rdata[ALT_STATUS_BIT];
          if (r_reg.prev_ok && cyc.rdata[ALT_STATUS_BIT] == r_reg.prev_alt) begin
            // status bit stopped alternating: next access allowed [RULE21]
            r_next.done = 1'b1;
            r_next.busy = 1'b0;
            r_next.st = H_IDLE;
          end else if (r_reg.poll_cnt >= POLL_W'(TWC_CYC)) begin
            r_next.tmo = 1'b1;
            r_next.busy = 1'b0;
            r_next.st = H_IDLE;
          end else begin
            r_next.st = H_POLL;
          end
        end
      end
      default: r_next = PFPP_HOST_RST;
    endcase
    // window closes early so the next falling strobe lands inside it [RULE7]
    r_next.ready = !r_next.pend_valid &&
                   (r_next.st == H_IDLE || (r_next.st == H_GAP && r_next.gap_cnt < GAP_ACCEPT_CYC));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= PFPP_HOST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cyc.req = r_reg.req;
  assign cyc.wr = r_reg.wr;
  assign cyc.addr = r_reg.addr;
  assign cyc.wdata = r_reg.wdata;

  assign cmd_ready_o = r_reg.ready;
  assign rsp_valid_o = r_reg.rsp_valid;
  assign rsp_data_o = r_reg.rsp_data;
  assign busy_o = r_reg.busy;
  assign prog_done_o = r_reg.done;
  assign prog_timeout_o = r_reg.tmo;
  assign page_partial_o = r_reg.partial;

  pfpp_bus_cycle u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc(cyc.engine),
    .ce_n_o(flash_ce_n_o),
    .oe_n_o(flash_oe_n_o),
    .we_n_o(flash_we_n_o),
    .addr_o(flash_addr_o),
    .dq_i(flash_dq_i),
    .dq_o(flash_dq_o),
    .dq_oe_o(flash_dq_oe_o)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_gap_accept_window: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == H_GAP && cmd_ready_o) |-> r_reg.gap_cnt < GAP_ACCEPT_CYC) // [RULE7]
    else $error("load accepted too late in window");
  a_gap_expiry_poll: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == H_GAP && r_reg.gap_cnt == GAP_CYC - 12'h001 && !take) |=> r_reg.st == H_POLL) // [RULE7]
    else $error("window expiry not followed by polling");
  a_same_page_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc.req && cyc.wr && !r_reg.seq_active && r_reg.page_valid) |->
      cyc.addr[ADDR_W-1:PAGE_LSB] == r_reg.page) // [RULE8]
    else $error("page changed during load");
  a_poll_only_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc.req && (r_reg.st == H_PCHK || r_reg.st == H_POLL)) |-> !cyc.wr && cyc.addr == r_reg.last_addr) // [RULE21]
    else $error("access issued before completion");
  a_partial_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == H_GAP && r_reg.gap_cnt == GAP_CYC - 12'h001 && r_reg.page_valid && !(&r_reg.mask))
      |=> page_partial_o) // [RULE6]
    else $error("partial page not flagged");
  a_lock_seq_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(r_reg.seq_active) && r_reg.seq_id == SEQ_LOCK_ON) |-> r_reg.st == H_GAP && !r_reg.page_valid) // [RULE14]
    else $error("lock prefix not followed by load window");
  a_lock_seq_len: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(r_reg.seq_active) && r_reg.seq_id == SEQ_LOCK_ON) |-> $past(r_reg.seq_idx) == 3'h2) // [RULE13]
    else $error("lock sequence length wrong");
  a_erase_seq_len: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(r_reg.seq_active) && r_reg.seq_id == SEQ_ERASE) |-> $past(r_reg.seq_idx) == 3'h5) // [RULE22]
    else $error("erase sequence length wrong");

  c_read_done: cover property (@(posedge clk_i) disable iff (rst_i) rsp_valid_o);
  c_prog_done: cover property (@(posedge clk_i) disable iff (rst_i) prog_done_o);
  c_prog_timeout: cover property (@(posedge clk_i) disable iff (rst_i) prog_timeout_o);
  c_erase_seq: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(r_reg.seq_active) && r_reg.seq_id == SEQ_ERASE);

endmodule

// File: sim/pfpp_flash_model.sv
`timescale 1ns/1ns
module pfpp_flash_model
  import pfpp_pkg::*;
#(
  parameter logic [5:0][ADDR_W+DATA_W-1:0] ON_TBL = '0,
  parameter logic [5:0][ADDR_W+DATA_W-1:0] OFF_TBL = '0,
  parameter logic [5:0][ADDR_W+DATA_W-1:0] ERASE_TBL = '0
) (
  // strobes and address
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // data pins
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  // write time and fault count
  input wire logic [31:0] twc_ns_i,
  output logic [31:0] err_o
);
  logic [DATA_W-1:0] mem [0:2**ADDR_W-1];
  logic [ADDR_W+DATA_W-1:0] ld_q [$];
  logic [ADDR_W-1:0] a_lat;
  logic [DATA_W-1:0] last_d = 8'h00;
  logic lock = 1'b0;
  logic busy = 1'b0;
  logic alt = 1'b0;
  time t_fall = 0;
  time t_rise = 0;
  int err = 0;

  initial foreach (mem[i]) mem[i] = 8'hff;
  assign err_o = err;
  assign dq_oe_o = !ce_n_i && !oe_n_i && we_n_i;
  assign dq_o = busy ? {~last_d[7], alt, last_d[5:0]} : mem[addr_i];

  always @(negedge oe_n_i) if (busy) alt = ~alt;

  always @(negedge we_n_i or negedge ce_n_i) begin
    if (!we_n_i && !ce_n_i) begin
      a_lat = addr_i;
      t_fall = $time;
    end
  end

  // only the first of the two rising strobes takes data
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (we_n_i ^ ce_n_i) begin
      if (!oe_n_i || busy) err++;
      else if ($time - t_fall >= 15) begin
        ld_q.push_back({a_lat, dq_i});
        t_rise = $time;
      end
    end
  end

  function automatic logic hit(input logic [5:0][ADDR_W+DATA_W-1:0] t, input int n);
    if (ld_q.size() < n) return 1'b0;
    for (int i = 0; i < n; i++) if (ld_q[i] !== t[i]) return 1'b0;
    return 1'b1;
  endfunction

  task automatic program_page();
    int n;
    logic wr;
    logic [ADDR_W-PAGE_LSB-1:0] pg;
    n = 0;
    wr = !lock;
    if (hit(ERASE_TBL, 6)) begin
      foreach (mem[i]) mem[i] = 8'hff;
      n = 6;
    end else if (hit(OFF_TBL, 6)) begin
      lock = 1'b0;
      n = 6;
    end else if (hit(ON_TBL, 3)) begin
      lock = 1'b1;
      wr = 1'b1;
      n = 3;
    end
    if (wr && ld_q.size() > n) begin
      pg = ld_q[n][22:14];
      for (int i = 0; i < PAGE_BYTES; i++) mem[{pg, 6'(i)}] = ~mem[{pg, 6'(i)}];
      for (int i = n; i < ld_q.size(); i++) mem[ld_q[i][22:8]] = ld_q[i][7:0];
    end
    last_d = ld_q[ld_q.size()-1][7:0];
    ld_q.delete();
    busy = 1'b1;
    #(twc_ns_i);
    busy = 1'b0;
  endtask

  always begin
    #40;
    if (ld_q.size() > 0 && $time - t_rise >= GAP_US * 1000) program_page();
  end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  import pfpp_pkg::*;
  localparam int TWC = 200;
  // sequence codes are arbitrary
  localparam logic [5:0][22:0] LK_ON = {69'h0, 15'h0155, 8'h3c, 15'h02aa, 8'hc3, 15'h0155, 8'h81};
  localparam logic [5:0][22:0] LK_OFF = {15'h0155, 8'h24, 15'h02aa, 8'h42, 15'h0155, 8'h18,
                                         15'h0155, 8'h66, 15'h02aa, 8'hc3, 15'h0155, 8'h81};
  localparam logic [5:0][22:0] ER = {15'h0155, 8'h99, 15'h02aa, 8'h42, 15'h0155, 8'h18,
                                     15'h0155, 8'h77, 15'h02aa, 8'hc3, 15'h0155, 8'h81};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_op_i = 2'h0;
  logic [ADDR_W-1:0] cmd_addr_i = 15'h0000;
  logic [DATA_W-1:0] cmd_data_i = 8'h00;
  logic cmd_ready_o, rsp_valid_o, busy_o, prog_done_o, prog_timeout_o, page_partial_o;
  logic ce_n, oe_n, we_n, h_oe, m_oe;
  logic [ADDR_W-1:0] f_addr;
  logic [DATA_W-1:0] rsp_data_o, h_dq, m_dq, dq_w, rd_v;
  logic [DATA_W-1:0] dq_last = 8'h00;
  logic [31:0] m_err;
  logic [31:0] dev_twc = 32'd4000;
  int fail_count = 0, num_checks = 0, n_done = 0, n_tmo = 0, n_part = 0, cyc = 0;

  always #20 clk_i = ~clk_i;
  // a released data line shows the inverse of its last level
  always_comb dq_w = m_oe ? m_dq : (h_oe ? h_dq : ~dq_last);
  always @(posedge clk_i) if (m_oe || h_oe) dq_last <= dq_w;

  always @(negedge clk_i) begin
    if (prog_done_o === 1'b1) n_done++;
    if (prog_timeout_o === 1'b1) n_tmo++;
    if (page_partial_o === 1'b1) n_part++;
    if (m_oe === 1'b1 && h_oe === 1'b1) `CHK(h_oe, 1'b0)
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  pfpp_host #(.TWC_CYC(TWC), .SEQ_LOCK_ON_TBL(LK_ON), .SEQ_LOCK_OFF_TBL(LK_OFF), .SEQ_ERASE_TBL(ER)) u_pfpp_host (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .busy_o(busy_o), .prog_done_o(prog_done_o), .prog_timeout_o(prog_timeout_o), .page_partial_o(page_partial_o),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_addr_o(f_addr), .flash_dq_i(dq_w),
    .flash_dq_o(h_dq), .flash_dq_oe_o(h_oe));

  pfpp_flash_model #(.ON_TBL(LK_ON), .OFF_TBL(LK_OFF), .ERASE_TBL(ER)) u_pfpp_flash_model (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(f_addr), .dq_i(dq_w), .dq_o(m_dq), .dq_oe_o(m_oe),
    .twc_ns_i(dev_twc), .err_o(m_err));

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int i;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    for (i = 0; i < 8000; i++) begin
      @(posedge clk_i);
      if (cmd_ready_o === 1'b1) break;
    end
    cmd_valid_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int i;
    cmd(OP_READ, a, 8'h00);
    for (i = 0; i < 8000; i++) begin
      @(posedge clk_i);
      if (rsp_valid_o === 1'b1) break;
    end
    d = rsp_data_o;
  endtask

  task automatic wait_end();
    int i;
    for (i = 0; i < 8000; i++) begin
      @(posedge clk_i);
      if (prog_done_o === 1'b1 || prog_timeout_o === 1'b1) break;
    end
  endtask

  // reverse order on purpose
  task automatic load_page(input logic [8:0] pg, input int n, input logic [7:0] base);
    for (int i = n - 1; i >= 0; i--) cmd(OP_LOAD, {pg, 6'(i)}, base + 8'(i));
  endtask

  task automatic chk_page(input logic [8:0] pg, input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      rd({pg, 6'(i)}, rd_v);
      `CHK(rd_v, base + 8'(i))
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    `CHK({cmd_ready_o, ce_n, oe_n, we_n, h_oe, busy_o}, 6'h3c)
  endtask

  task automatic t_full();
    int d0;
    int p0;
    d0 = n_done;
    p0 = n_part;
    load_page(9'h003, 64, 8'h10);
    rd({9'h003, 6'h3f}, rd_v);
    `CHK(rd_v, 8'h4f)
    `CHK(n_done - d0, 1)
    `CHK(n_part - p0, 0)
    chk_page(9'h003, 64, 8'h10);
  endtask

  task automatic t_partial();
    int p0;
    p0 = n_part;
    load_page(9'h004, 2, 8'h40);
    wait_end();
    `CHK(busy_o, 1'b0)
    `CHK(n_part - p0, 1)
    chk_page(9'h004, 2, 8'h40);
  endtask

  task automatic t_lock();
    int d0;
    cmd(OP_SEQ, 15'h0000, {6'h00, SEQ_LOCK_ON});
    load_page(9'h005, 64, 8'h20);
    wait_end();
    chk_page(9'h005, 64, 8'h20);
    d0 = n_done;
    load_page(9'h005, 64, 8'h70);
    wait_end();
    `CHK(n_done - d0, 1)
    chk_page(9'h005, 64, 8'h20);
    cmd(OP_SEQ, 15'h0000, {6'h00, SEQ_LOCK_ON});
    load_page(9'h005, 64, 8'h30);
    wait_end();
    chk_page(9'h005, 64, 8'h30);
    cmd(OP_SEQ, 15'h0000, {6'h00, SEQ_LOCK_OFF});
    wait_end();
    load_page(9'h005, 64, 8'h50);
    wait_end();
    chk_page(9'h005, 64, 8'h50);
  endtask

  task automatic t_erase();
    cmd(OP_SEQ, 15'h0000, {6'h00, SEQ_ERASE});
    wait_end();
    rd({9'h003, 6'h00}, rd_v);
    `CHK(rd_v, 8'hff)
    rd({9'h005, 6'h3f}, rd_v);
    `CHK(rd_v, 8'hff)
  endtask

  // device slower than the poll limit
  task automatic t_slow();
    int t0;
    t0 = n_tmo;
    dev_twc <= 32'd24000;
    cmd(OP_LOAD, {9'h006, 6'h05}, 8'h9a);
    wait_end();
    `CHK(n_tmo - t0, 1)
    repeat (600) @(posedge clk_i);
    dev_twc <= 32'd4000;
    rd({9'h006, 6'h05}, rd_v);
    `CHK(rd_v, 8'h9a)
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_full();
    t_partial();
    t_lock();
    t_erase();
    t_slow();
    `CHK(m_err, 32'h0)
    results();
  end
endmodule
